// *** rtl/bsc_bootstrap_config.sv ***
// Top of the bootstrap strap block: latching, decode, power save and monitor.
//
// Operation
// - All sixteen strap bits and four port transmit-enable straps sampled during every reset.
// - Strap bit 3 selects managed serial or unmanaged serial with EEPROM.
// - In managed serial mode, strap bit 0 enables serial input filtering.
// - In managed serial mode, strap bits 6 to 4 give the device identifier.
// - Strap bit 7 enables the EEPROM configuration load after reset.
// - Strap bit 9 enables hot-swap; then transmit-enable straps give module types.
// - With strap bit 11, each MAC sleeps when idle and wakes on activity.
// - With strap bit 12, flag any machine non-idle beyond five seconds.
// - A stuck machine triggers either a device reset or a CPU interrupt.
// - Monitor runs only with strap set and CPU monitor configuration written.
// - Ports 0 to 3 use PHY addresses 08h to 0Bh in order.
// - Uplink port 9 uses PHY address 10h.
// - Control frames are executed in managed mode and rejected when unmanaged.
// - Power-saving strap high turns MAC power saving on, low turns it off.
// - Module-detect strap high enables PHY insertion detection, low disables it.
// - Latched transmit-enable straps stay readable through a readback register.
`timescale 1ns/1ps
module bsc_bootstrap_config
	import bsc_pkg::*;
#(
	parameter int NUM_SM = 8,
	parameter int unsigned STUCK_CYCLES = 32'(STUCK_CYCLES_DEF),
	parameter int unsigned IDLE_CYCLES = 32'(IDLE_CYCLES_DEF)
)
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// Strap pins.
	input wire logic [STRAP_W-1:0] strapPins,
	input wire logic [TXEN_W-1:0] portTxEnableStraps,
	// Decoded configuration.
	output logic mgmtUnmanaged,
	output logic serialInputFilterEn,
	output logic [ID_W-1:0] deviceId,
	output logic eepromLoadReq,
	output logic hotSwapEn,
	output logic [TXEN_W-1:0] portModuleType,
	output logic [TXEN_W-1:0] strapReadbackReg,
	output logic powerSaveEn,
	output logic [NUM_PORTS*PHY_ADDR_W-1:0] phyAddr,
	// MAC activity and power save, ports 0-3 then uplink.
	input wire logic [NUM_PORTS-1:0] portActivity,
	output logic [NUM_PORTS-1:0] macPowerSave,
	// Control frame gate.
	input wire logic ctrlFrameValid,
	output logic ctrlFrameAccept,
	output logic ctrlFrameReject,
	// Stuck-machine monitor.
	input wire logic [NUM_SM-1:0] smBusy,
	input wire logic monCfgWrite,
	input wire bsc_mon_cfg_s monCfgData,
	input wire logic monIrqClear,
	output logic [NUM_SM-1:0] smStuck,
	output logic monResetReq,
	output logic monIrq
);

	////////////////////////////////////////////////////////////////////////////
	// Strap capture.

	bsc_strap_s straps_q;

	bsc_strap_latch u_latch (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.strapPins(strapPins),
		.portTxEnableStraps(portTxEnableStraps),
		.straps_q(straps_q)
	);

	////////////////////////////////////////////////////////////////////////////
	// Strap decode. These are wires off the latch, so they are already stable.

	// Mode select and the options that only mean something in managed serial mode.
	assign mgmtUnmanaged = straps_q.pins[BIT_MGMT];
	assign serialInputFilterEn = (mgmtUnmanaged == MGMT_MANAGED) && straps_q.pins[BIT_FILTER];
	assign deviceId = (mgmtUnmanaged == MGMT_MANAGED) ?
		straps_q.pins[BIT_ID_HI:BIT_ID_LO] : '0;

	// Hot-swap detection and module types; readback always shows the raw straps.
	assign hotSwapEn = straps_q.pins[BIT_HOTSWAP];
	assign portModuleType = hotSwapEn ? straps_q.txEn : '0;
	assign strapReadbackReg = straps_q.txEn;
	assign powerSaveEn = straps_q.pins[BIT_PSAVE];

	// Control frames are only decoded in managed mode.
	assign ctrlFrameAccept = ctrlFrameValid && (mgmtUnmanaged == MGMT_MANAGED);
	assign ctrlFrameReject = ctrlFrameValid && (mgmtUnmanaged == MGMT_UNMANAGED);

	////////////////////////////////////////////////////////////////////////////
	// Fixed PHY addresses. Software handles any PHY strapped elsewhere.

	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_phy
		if (p == UPLINK_IDX) begin : g_up
			assign phyAddr[p*PHY_ADDR_W +: PHY_ADDR_W] = PHY_ADDR_UPLINK;
		end else begin : g_rmii
			assign phyAddr[p*PHY_ADDR_W +: PHY_ADDR_W] =
				PHY_ADDR_RMII_BASE + PHY_ADDR_W'(p);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// EEPROM load request: one pulse on the first edge after reset release.

	logic inReset_q;
	logic eepromLoadReq_q;

	// Remember that the previous edge was still in reset.
	always_ff @(posedge sys_clk) begin
		inReset_q <= !nrst;
	end

	// A single request so the loader cannot be restarted by a stuck level.
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			eepromLoadReq_q <= 1'b0;
		end else begin
			eepromLoadReq_q <= inReset_q && straps_q.pins[BIT_EEPROM];
		end
	end
	assign eepromLoadReq = eepromLoadReq_q;

	////////////////////////////////////////////////////////////////////////////
	// MAC power saving, one idle counter per port.

	localparam int IW = $clog2(IDLE_CYCLES + 1);
	localparam logic [IW-1:0] IDLE_LAST = IW'(IDLE_CYCLES - 1);

	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_psave
		logic [IW-1:0] idle_q;
		logic sleep_q;
		// Activity wakes the MAC in the next cycle; no hysteresis is applied.
		always_ff @(posedge sys_clk) begin
			if (!nrst || !powerSaveEn || portActivity[p]) begin
				idle_q <= '0;
				sleep_q <= 1'b0;
			end else if (idle_q == IDLE_LAST) begin
				sleep_q <= 1'b1;
			end else begin
				idle_q <= idle_q + IW'(1);
			end
		end
		assign macPowerSave[p] = sleep_q;
	end

	////////////////////////////////////////////////////////////////////////////
	// Stuck-machine monitor.

	bsc_mon_e monState_q;
	bsc_mon_cfg_s monCfg_q;
	logic monCfgSeen_q;
	logic monResetReq_q;
	logic monIrq_q;
	logic monActive;
	logic [NUM_SM-1:0] stuckPulse;
	logic stuckEvent;

	// CPU configuration; a write of any kind marks the monitor as configured.
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			monCfg_q <= '0;
			monCfgSeen_q <= 1'b0;
		end else if (monCfgWrite) begin
			monCfg_q <= monCfgData;
			monCfgSeen_q <= 1'b1;
		end
	end

	assign monActive = (monState_q == MON_WATCH);

	bsc_stuck_timer #(
		.N(NUM_SM),
		.LIMIT(STUCK_CYCLES)
	) u_timer (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.enable(monActive),
		.smBusy(smBusy),
		.stuck_q(smStuck),
		.stuckPulse_q(stuckPulse)
	);
	assign stuckEvent = |stuckPulse;

	// Sequencing: watch only when strap and CPU both allow, latch a trip.
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			monState_q <= MON_OFF;
		end else begin
			case (monState_q)
				MON_OFF: begin
					if (straps_q.pins[BIT_TIMEOUT] && monCfgSeen_q && monCfg_q.armed) begin
						monState_q <= MON_WATCH;
					end
				end
				MON_WATCH: begin
					if (!monCfg_q.armed) begin
						monState_q <= MON_OFF;
					end else if (stuckEvent) begin
						monState_q <= MON_TRIPPED;
					end
				end
				MON_TRIPPED: begin
					if (!monCfg_q.armed) begin
						monState_q <= MON_OFF;
					end else if (!monIrq_q && !monResetReq_q) begin
						monState_q <= MON_WATCH;
					end
				end
				default: begin
					monState_q <= MON_OFF;
				end
			endcase
		end
	end

	// Reset request is a one-cycle pulse; the system reset logic stretches it.
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			monResetReq_q <= 1'b0;
		end else begin
			monResetReq_q <= monActive && stuckEvent && !monCfg_q.actionIrq;
		end
	end

	// Sticky interrupt; a new trip in the clearing cycle wins over the clear.
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			monIrq_q <= 1'b0;
		end else if (monActive && stuckEvent && monCfg_q.actionIrq) begin
			monIrq_q <= 1'b1;
		end else if (monIrqClear) begin
			monIrq_q <= 1'b0;
		end
	end

	assign monResetReq = monResetReq_q;
	assign monIrq = monIrq_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	a_strap_capture: assert property ($rose(nrst) |->
		straps_q == {$past(strapPins), $past(portTxEnableStraps)})
		else $error("Straps not captured at reset release.");

	a_strap_hold: assert property ($past(nrst) |-> $stable(straps_q))
		else $error("Latched straps changed outside reset.");

	a_mode_select: assert property ($rose(nrst) |->
		mgmtUnmanaged == $past(strapPins[BIT_MGMT]))
		else $error("Management mode does not follow its strap.");

	a_filter_id: assert property (mgmtUnmanaged |-> !serialInputFilterEn && deviceId == '0)
		else $error("Serial options active outside managed mode.");

	a_dev_id: assert property ($rose(nrst) && !$past(strapPins[BIT_MGMT]) |->
		deviceId == $past(strapPins[BIT_ID_HI:BIT_ID_LO]))
		else $error("Device identifier does not follow its straps.");

	a_eeprom_pulse: assert property ($rose(nrst) && straps_q.pins[BIT_EEPROM] |=>
		eepromLoadReq ##1 !eepromLoadReq[*3])
		else $error("EEPROM load request is not a single pulse.");

	a_module_type: assert property (!hotSwapEn |-> portModuleType == '0)
		else $error("Module type shown with hot-swap off.");

	a_psave_wake: assert property (macPowerSave[0] && portActivity[0] |=> !macPowerSave[0])
		else $error("MAC stayed asleep despite activity.");

	a_psave_off: assert property (!powerSaveEn |=> macPowerSave == '0)
		else $error("MAC power saving active with strap low.");

	a_mon_gate: assert property ($rose(monIrq) || monResetReq |->
		$past(straps_q.pins[BIT_TIMEOUT]) && $past(monCfgSeen_q))
		else $error("Monitor acted without strap and configuration.");

	a_mon_action: assert property (monActive && stuckEvent |=>
		(monCfg_q.actionIrq ? monIrq && !monResetReq : monResetReq))
		else $error("Stuck event produced the wrong action.");

	a_ctrl_reject: assert property (ctrlFrameValid && mgmtUnmanaged |->
		ctrlFrameReject && !ctrlFrameAccept)
		else $error("Control frame accepted in unmanaged mode.");

	// The flag is set by the busy level of the edge before it shows, which may be gone now.
	a_stuck_cause: assert property ($rose(smStuck[0]) |->
		$past(smBusy[0], 2) && $past(smBusy[0]))
		else $error("Machine flagged stuck while idle.");

	c_eeprom_req: cover property (eepromLoadReq);
	c_mac_sleep: cover property ($rose(macPowerSave[0]));
	c_mon_irq: cover property ($rose(monIrq));
	c_ctrl_reject: cover property (ctrlFrameReject);

endmodule

// *** rtl/bsc_pkg.sv ***
// Shared constants and types for the bootstrap strap configuration block.
package bsc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Strap widths and bit positions within the strap pin bus.
	localparam int STRAP_W = 16;
	localparam int TXEN_W = 4;
	localparam int BIT_FILTER = 0;
	localparam int BIT_MGMT = 3;
	localparam int BIT_ID_LO = 4;
	localparam int BIT_ID_HI = 6;
	localparam int BIT_EEPROM = 7;
	localparam int BIT_HOTSWAP = 9;
	localparam int BIT_PSAVE = 11;
	localparam int BIT_TIMEOUT = 12;
	localparam int ID_W = BIT_ID_HI - BIT_ID_LO + 1;

	// Management mode encoding of the mode strap.
	localparam logic MGMT_MANAGED = 1'b0;
	localparam logic MGMT_UNMANAGED = 1'b1;

	////////////////////////////////////////////////////////////////////////////
	// Fixed PHY management addresses: ports 0-3 then the uplink port 9.
	localparam int NUM_PORTS = 5;
	localparam int PHY_ADDR_W = 5;
	localparam logic [PHY_ADDR_W-1:0] PHY_ADDR_RMII_BASE = 5'h08;
	localparam logic [PHY_ADDR_W-1:0] PHY_ADDR_UPLINK = 5'h10;
	localparam int UPLINK_IDX = 4;

	////////////////////////////////////////////////////////////////////////////
	// Timing: clock rate, stuck-machine timeout and MAC idle time.
	localparam longint CLK_HZ = 200_000_000;
	localparam longint STUCK_TIME_S = 5;
	localparam longint STUCK_CYCLES_DEF = STUCK_TIME_S * CLK_HZ;
	localparam longint IDLE_TIME_NS = 10_000;
	localparam longint IDLE_CYCLES_DEF = (IDLE_TIME_NS * CLK_HZ + 64'd999_999_999) / 1_000_000_000;

	////////////////////////////////////////////////////////////////////////////
	// Latched straps as one bundle.
	typedef struct packed {
		logic [STRAP_W-1:0] pins;
		logic [TXEN_W-1:0] txEn;
	} bsc_strap_s;

	// Monitor configuration written by the CPU.
	typedef struct packed {
		logic armed;
		logic actionIrq;
	} bsc_mon_cfg_s;

	// Monitor sequencing, Gray coded along the usual path.
	typedef enum logic [1:0] {
		MON_OFF = 2'b00,
		MON_WATCH = 2'b01,
		MON_TRIPPED = 2'b11
	} bsc_mon_e;

endpackage

// *** rtl/bsc_strap_latch.sv ***
// Strap capture register, loaded during reset and frozen afterwards.
`timescale 1ns/1ps
module bsc_strap_latch
	import bsc_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// Strap pins.
	input wire logic [STRAP_W-1:0] strapPins,
	input wire logic [TXEN_W-1:0] portTxEnableStraps,
	// Latched values.
	output bsc_strap_s straps_q
);

	// Follows the pins at every edge while reset is held, holds once released.
	// Sampling through the whole reset lets the pull resistors settle first.
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			straps_q <= '{pins: strapPins, txEn: portTxEnableStraps};
		end
	end // Hold in normal operation.

endmodule

// *** rtl/bsc_stuck_timer.sv ***
// Per state machine busy-time counters that flag a machine stuck non-idle.
`timescale 1ns/1ps
module bsc_stuck_timer
	import bsc_pkg::*;
#(
	parameter int N = 8,
	parameter int unsigned LIMIT = 1000
)
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// Control and observed machines.
	input wire logic enable,
	input wire logic [N-1:0] smBusy,
	// Results.
	output logic [N-1:0] stuck_q,
	output logic [N-1:0] stuckPulse_q
);

	localparam int CW = $clog2(LIMIT + 1);
	localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

	// One counter per machine; it restarts whenever the machine goes idle.
	for (genvar i = 0; i < N; i++) begin : g_mach
		logic [CW-1:0] cnt_q;
		always_ff @(posedge sys_clk) begin
			if (!nrst || !enable || !smBusy[i]) begin
				cnt_q <= '0;
				stuck_q[i] <= 1'b0;
				stuckPulse_q[i] <= 1'b0;
			end else if (cnt_q == LAST && !stuck_q[i]) begin
				stuck_q[i] <= 1'b1;
				stuckPulse_q[i] <= 1'b1;
			end else begin
				stuckPulse_q[i] <= 1'b0;
				if (!stuck_q[i]) begin
					cnt_q <= cnt_q + CW'(1);
				end
			end
		end
	end

endmodule

// *** testbench/bsc_bootstrap_config_tb.sv ***
// Self-checking bench for the bootstrap strap block.
`timescale 1ns/1ps
module bsc_bootstrap_config_tb;
	import bsc_pkg::*;

	localparam int IDLE = 8;
	localparam int STUCK = 20;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [15:0] pullLvl = '0;
	logic [3:0] txPull = '0;
	logic [15:0] strapPins;
	logic [3:0] portTxEnableStraps;
	logic mgmtUnmanaged, serialInputFilterEn, eepromLoadReq, hotSwapEn, powerSaveEn;
	logic [2:0] deviceId;
	logic [3:0] portModuleType, strapReadbackReg;
	logic [24:0] phyAddr;
	logic [4:0] portActivity = '0;
	logic [4:0] macPowerSave;
	logic ctrlFrameValid = 1'b0;
	logic ctrlFrameAccept, ctrlFrameReject;
	logic [7:0] smBusy = '0;
	logic [7:0] smStuck;
	logic monCfgWrite = 1'b0;
	bsc_mon_cfg_s monCfgData = '0;
	logic monIrqClear = 1'b0;
	logic monResetReq, monIrq;
	logic [31:0] seed = 32'h0000_0033;
	int mismatches = 0;
	int testsRun = 0;
	int n;

	////////////////////////////////////////////////////////////////////////////
	// Clock at 200 MHz.
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	// Resistor model and the block under test with short counts.
	bsc_strap_pullups u_bsc_strap_pullups (.sys_clk(sys_clk), .nrst(nrst),
		.pullLvl(pullLvl), .txPull(txPull), .strapPins(strapPins),
		.txStraps(portTxEnableStraps));
	bsc_bootstrap_config #(.NUM_SM(8), .STUCK_CYCLES(STUCK), .IDLE_CYCLES(IDLE))
	u_bsc_bootstrap_config (.sys_clk(sys_clk), .nrst(nrst), .strapPins(strapPins),
		.portTxEnableStraps(portTxEnableStraps), .mgmtUnmanaged(mgmtUnmanaged),
		.serialInputFilterEn(serialInputFilterEn), .deviceId(deviceId),
		.eepromLoadReq(eepromLoadReq), .hotSwapEn(hotSwapEn),
		.portModuleType(portModuleType), .strapReadbackReg(strapReadbackReg),
		.powerSaveEn(powerSaveEn), .phyAddr(phyAddr), .portActivity(portActivity),
		.macPowerSave(macPowerSave), .ctrlFrameValid(ctrlFrameValid),
		.ctrlFrameAccept(ctrlFrameAccept), .ctrlFrameReject(ctrlFrameReject),
		.smBusy(smBusy), .monCfgWrite(monCfgWrite), .monCfgData(monCfgData),
		.monIrqClear(monIrqClear), .smStuck(smStuck), .monResetReq(monResetReq),
		.monIrq(monIrq));

	////////////////////////////////////////////////////////////////////////////
	// Helpers: random source, clock stepping, comparison and the verdict.
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Inputs always change one nanosecond after the rising edge.
	task automatic step(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", testsRun, mismatches);
		if (mismatches == 0 && testsRun > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// A wait that ran out of its bound ends the run.
	task automatic bounded(input int k, input int lim);
		if (k >= lim) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, k, lim);
			complete_run();
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Reference decode of the straps, worked out from the pin levels.
	task automatic chkStraps(input logic [15:0] p, input logic [3:0] t);
		logic [24:0] e;
		e = '0;
		for (int i = 0; i < 4; i++) e[i*5 +: 5] = 5'(8 + i);
		e[20 +: 5] = 5'h10;
		chk(mgmtUnmanaged, p[3]);
		chk(serialInputFilterEn, p[0] & ~p[3]);
		chk(deviceId, p[3] ? 3'h0 : p[6:4]);
		chk(hotSwapEn, p[9]);
		chk(portModuleType, p[9] ? t : 4'h0);
		chk(strapReadbackReg, t);
		chk(powerSaveEn, p[11]);
		chk(phyAddr, e);
	endtask

	// Ten cycles of reset, release, then load request, decode and frame gate.
	task automatic runReset(input logic [15:0] p, input logic [3:0] t);
		pullLvl = p;
		txPull = t;
		nrst = 1'b0;
		step(10);
		nrst = 1'b1;
		step(1);
		chk(eepromLoadReq, p[7]);
		step(1);
		chk(eepromLoadReq, 1'b0);
		chkStraps(p, t);
		ctrlFrameValid = 1'b1;
		step(1);
		chk({ctrlFrameAccept, ctrlFrameReject}, {~p[3], p[3]});
		ctrlFrameValid = 1'b0;
		step(5);
		chkStraps(p, t);
		$display("test reset with straps %h/%h done", p, t);
	endtask

	// Write the monitor configuration once, then let the sequencer settle.
	task automatic armMon(input logic arm, input logic irqAct);
		monCfgData = '{armed: arm, actionIrq: irqAct};
		monCfgWrite = 1'b1;
		step(1);
		monCfgWrite = 1'b0;
		step(2);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		logic [15:0] p;
		for (int i = 0; i < 8; i++) begin
			p = 16'(rnd());
			p[3] = i[0];
			runReset(p, 4'(rnd()));
		end
		// Power save and monitor enabled, managed mode.
		runReset(16'h1a81, 4'h5);
		portActivity = 5'h1f;
		step(1);
		portActivity = 5'h00;
		for (n = 0; n < 100 && macPowerSave !== 5'h1f; n++) step(1);
		bounded(n, 100);
		chk(n, IDLE);
		portActivity = 5'h04;
		step(1);
		chk(macPowerSave, 5'h1b);
		portActivity = 5'h00;
		$display("test power save done");
		// Stuck machine raises the interrupt, which a clear removes.
		armMon(1'b1, 1'b1);
		smBusy = 8'h08;
		for (n = 0; n < 100 && smStuck[3] !== 1'b1; n++) step(1);
		bounded(n, 100);
		chk(n, STUCK);
		step(1);
		chk({monIrq, monResetReq, smStuck}, {2'b10, 8'h08});
		smBusy = 8'h00;
		monIrqClear = 1'b1;
		step(1);
		monIrqClear = 1'b0;
		chk(monIrq, 1'b0);
		// Reset action chosen; two machines stuck together give one pulse.
		armMon(1'b1, 1'b0);
		smBusy = 8'h81;
		for (n = 0; n < 100 && smStuck !== 8'h81; n++) step(1);
		bounded(n, 100);
		chk(n, STUCK);
		step(1);
		chk({monResetReq, monIrq}, 2'b10);
		step(1);
		chk(monResetReq, 1'b0);
		smBusy = 8'h00;
		// Disarmed by the CPU: busy machines are no longer timed at all.
		armMon(1'b0, 1'b1);
		smBusy = 8'hff;
		step(30);
		chk({smStuck, monIrq, monResetReq}, 10'h000);
		smBusy = 8'h00;
		$display("test monitor trip done");
		// Straps off: no power save and no monitor even when configured.
		runReset(16'h0008, 4'ha);
		armMon(1'b1, 1'b1);
		smBusy = 8'hff;
		step(40);
		chk({macPowerSave, smStuck, monIrq, monResetReq}, 15'h0000);
		smBusy = 8'h00;
		$display("test straps disabled done");
		complete_run();
	end
endmodule

// *** testbench/bsc_strap_pullups.sv ***
// Strap resistor model: pull levels during reset, moving pin levels afterwards.
`timescale 1ns/1ps
module bsc_strap_pullups
	import bsc_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// Resistor pattern chosen by the bench.
	input wire logic [STRAP_W-1:0] pullLvl,
	input wire logic [TXEN_W-1:0] txPull,
	// Levels seen at the strap pins.
	output logic [STRAP_W-1:0] strapPins,
	output logic [TXEN_W-1:0] txStraps
);
	logic [STRAP_W+TXEN_W-1:0] pinNoise_q = '0;

	////////////////////////////////////////////////////////////////////////////
	// Out of reset the pins carry device traffic: each pin whose pull level equals its bit of
	// 20'h5_a5a5 toggles every cycle and the rest hold; a latch that kept following the pins would show it at once.
	always_ff @(posedge sys_clk) begin
		pinNoise_q <= ~pinNoise_q ^ {pullLvl, txPull} ^ 20'h5_a5a5;
	end

	// Resistors alone set the pins while reset is held.
	assign strapPins = nrst ? pinNoise_q[19:4] : pullLvl;
	assign txStraps = nrst ? pinNoise_q[3:0] : txPull;
endmodule
